// *** design/ebp_bus_holder.sv ***
/*
 * Bus holder bank: per line, remembers the last level seen on the pin and
 * offers it as a weak keeper drive while the line is not driven.
 * Assumes the bench resolves the pin from the strong enable first, then
 * the keeper enable, and that pin inputs are synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ebp_bus_holder #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_enable,
    input  wire logic [WIDTH-1:0] i_pin,
    input  wire logic [WIDTH-1:0] i_oe_next,
    output var  logic [WIDTH-1:0] o_keep_val,
    output var  logic [WIDTH-1:0] o_keep_en
);

    // One keeper cell per line
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_cell
            // Last level follows the pin; while kept the pin shows it anyway
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_keep_val[g] <= 1'b0;
                end else begin
                    o_keep_val[g] <= i_pin[g];
                end
            end
            // Keeper acts only where the strong driver lets go
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_keep_en[g] <= 1'b0;
                end else begin
                    o_keep_en[g] <= i_enable & ~i_oe_next[g];
                end
            end
        end
    endgenerate

endmodule // ebp_bus_holder

`default_nettype wire

// *** design/ebp_pin_ctrl.sv ***
/*
 * External bus pin control: decides per cycle which address and data lines
 * the device drives, floats or keeps, splits the address lines between
 * program, data and I/O space, and hands the pins to the host port in
 * 16-bit host mode. Control and status sit behind an APB slave.
 * Assumes one 250 MHz clock, synchronous pin inputs, and a bench that
 * resolves each pin from its output enable and keeper enable.
 */
// Decided for this implementation: register access over APB and the register addresses.
// Notes on behaviour
// - Low sixteen address lines address program, data or I/O by access kind
// - Upper seven address lines driven only for program space accesses
// - All address outputs float while the bus is held
// - Output-disable low floats every address and data line
// - Host-port wide mode turns low sixteen address lines into inputs
// - Data bus carries host transfers in host mode, else core transfers
// - Data floats unless outputting, and during reset or hold request
// - Address keepers hold last level on floating address lines
// - Data keepers hold last level on floating data lines
// - Software control bit enables or disables the data keepers
`timescale 1ns/1ps
`default_nettype none

module ebp_pin_ctrl
    import ebp_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // APB slave
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [31:0]         i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output var  logic                o_pready,
    output var  logic [31:0]         o_prdata,
    output var  logic                o_pslverr,
    // Device pins and core side
    input  wire logic                i_off_n,
    input  wire logic                i_device_reset_n,
    input  wire logic                i_hold_req,
    input  wire logic                i_host_port_wide_select,
    input  wire ebp_core_req_t       i_core,
    input  wire ebp_host_rd_t        i_host_rd,
    output var  logic                o_hold_ack,
    output var  logic                o_prog_sel,
    output var  logic                o_data_sel,
    output var  logic                o_io_sel,
    output var  logic [DATA_W-1:0]   o_core_rdata,
    output var  logic [LOW_W-1:0]    o_host_addr,
    output var  logic [DATA_W-1:0]   o_host_wdata,
    // Address pin triple plus keeper
    input  wire logic [ADDR_W-1:0]   i_ext_address_bus,
    output var  logic [ADDR_W-1:0]   o_ext_address_bus,
    output var  logic [ADDR_W-1:0]   o_ext_address_bus_oe,
    output var  logic [ADDR_W-1:0]   o_ext_address_bus_keep,
    output var  logic [ADDR_W-1:0]   o_ext_address_bus_keep_en,
    // Data pin triple plus keeper
    input  wire logic [DATA_W-1:0]   i_ext_data_bus,
    output var  logic [DATA_W-1:0]   o_ext_data_bus,
    output var  logic [DATA_W-1:0]   o_ext_data_bus_oe,
    output var  logic [DATA_W-1:0]   o_ext_data_bus_keep,
    output var  logic [DATA_W-1:0]   o_ext_data_bus_keep_en
);

    ebp_bus_state_t    bus_state_reg;
    ebp_bus_state_t    bus_state_next;
    logic [1:0]        ctrl_reg;
    logic              access_phase;
    logic              core_active;
    logic              addr_low_drive;
    logic              addr_high_drive;
    logic              data_drive;
    logic [ADDR_W-1:0] addr_oe_next;
    logic [DATA_W-1:0] data_oe_next;
    logic [DATA_W-1:0] data_out_next;
    logic [31:0]       status_word;

    // Bus ownership: hold request hands the bus over, release takes it back
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            EBP_BUS_OWN: begin
                if (i_hold_req) begin
                    bus_state_next = EBP_BUS_HELD;
                end
            end
            EBP_BUS_HELD: begin
                if (!i_hold_req) begin
                    bus_state_next = EBP_BUS_OWN;
                end
            end
            default: begin
                bus_state_next = EBP_BUS_OWN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_state_reg <= EBP_BUS_OWN;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_hold_ack <= 1'b0;
        end else begin
            o_hold_ack <= (bus_state_next == EBP_BUS_HELD);
        end
    end

    // Drive decisions; output-disable gates every term last
    assign core_active = i_core.req && (i_core.kind != EBP_KIND_NONE)
                         && (bus_state_next == EBP_BUS_OWN);
    assign addr_low_drive  = i_off_n && core_active
                             && !i_host_port_wide_select;
    assign addr_high_drive = i_off_n && core_active
                             && (i_core.kind == EBP_KIND_PROG);
    // Host mode gives the data pins to the host port only
    assign data_drive = i_off_n && i_device_reset_n && !i_hold_req
                        && (i_host_port_wide_select ? i_host_rd.drive
                            : (core_active && i_core.wr));
    assign addr_oe_next = {{HIGH_W{addr_high_drive}},
                           {LOW_W{addr_low_drive}}};
    assign data_oe_next = {DATA_W{data_drive}};
    assign data_out_next = i_host_port_wide_select ? i_host_rd.rdata
                           : i_core.wdata;

    // Pin enables are registered so every output comes from a flop
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ext_address_bus_oe <= '0;
            o_ext_data_bus_oe    <= '0;
        end else begin
            o_ext_address_bus_oe <= addr_oe_next;
            o_ext_data_bus_oe    <= data_oe_next;
        end
    end

    // Driven values; upper lines keep last program address otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ext_address_bus <= '0;
            o_ext_data_bus    <= '0;
        end else begin
            if (addr_low_drive) begin
                o_ext_address_bus[LOW_W-1:0] <= i_core.addr[LOW_W-1:0];
            end
            if (addr_high_drive) begin
                o_ext_address_bus[ADDR_W-1:LOW_W] <=
                    i_core.addr[ADDR_W-1:LOW_W];
            end
            if (data_drive) begin
                o_ext_data_bus <= data_out_next;
            end
        end
    end

    // Space strobes tell external decoders which target is addressed
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prog_sel <= 1'b0;
            o_data_sel <= 1'b0;
            o_io_sel   <= 1'b0;
        end else begin
            // Follows the upper lines, which stay driven in host mode
            o_prog_sel <= addr_high_drive;
            o_data_sel <= addr_low_drive && (i_core.kind == EBP_KIND_DATA);
            o_io_sel   <= addr_low_drive && (i_core.kind == EBP_KIND_IO);
        end
    end

    // Captured pin levels for the core read path and the host port
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_core_rdata <= '0;
            o_host_addr  <= '0;
            o_host_wdata <= '0;
        end else begin
            o_core_rdata <= i_ext_data_bus;
            if (i_host_port_wide_select) begin
                o_host_addr  <= i_ext_address_bus[LOW_W-1:0];
                o_host_wdata <= i_ext_data_bus;
            end
        end
    end

    // Address keepers; can be switched off to save a little leakage
    ebp_bus_holder #(
        .WIDTH (ADDR_W)
    ) u_addr_holder (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_enable   (ctrl_reg[CTRL_AHOLD_BIT]),
        .i_pin      (i_ext_address_bus),
        .i_oe_next  (addr_oe_next),
        .o_keep_val (o_ext_address_bus_keep),
        .o_keep_en  (o_ext_address_bus_keep_en)
    );

    // Data keepers under software control
    ebp_bus_holder #(
        .WIDTH (DATA_W)
    ) u_data_holder (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_enable   (ctrl_reg[CTRL_DHOLD_BIT]),
        .i_pin      (i_ext_data_bus),
        .i_oe_next  (data_oe_next),
        .o_keep_val (o_ext_data_bus_keep),
        .o_keep_en  (o_ext_data_bus_keep_en)
    );

    // APB: answer one cycle into the access phase, never earlier
    assign access_phase = i_psel && i_penable && !o_pready;

    assign status_word = {26'h000_0000,
                          !i_device_reset_n,
                          |o_ext_data_bus_oe,
                          |o_ext_address_bus_oe,
                          !i_off_n,
                          i_host_port_wide_select,
                          o_hold_ack};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= access_phase;
        end
    end

    // Control register write; the keeper bits are the only writable state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (access_phase && i_pwrite
                     && (i_paddr == CTRL_OFFSET)) begin
            ctrl_reg <= i_pwdata[1:0];
        end
    end

    // Read data and error; unmapped addresses answer with an error
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else if (access_phase) begin
            if (i_paddr == CTRL_OFFSET) begin
                o_prdata  <= {30'h0000_0000, ctrl_reg};
                o_pslverr <= 1'b0;
            end else if (i_paddr == STATUS_OFFSET) begin
                o_prdata  <= i_pwrite ? 32'h0000_0000 : status_word;
                o_pslverr <= i_pwrite;
            end else begin
                o_prdata  <= '0;
                o_pslverr <= 1'b1;
            end
        end else begin
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end
    end

    // Checks on the pin behaviour and the APB answer timing
    a_off_floats_all: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_off_n |=> (o_ext_address_bus_oe == '0)
                     && (o_ext_data_bus_oe == '0))
        else $error("pins driven after output-disable");

    a_hold_floats_addr: assert property (@(posedge i_clk) disable iff (i_rst)
        o_hold_ack |-> (o_ext_address_bus_oe == '0))
        else $error("address driven in hold mode");

    a_data_rst_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_device_reset_n || i_hold_req) |=> (o_ext_data_bus_oe == '0))
        else $error("data driven in reset or hold");

    a_upper_prog_only: assert property (@(posedge i_clk) disable iff (i_rst)
        (|o_ext_address_bus_oe[ADDR_W-1:LOW_W]) |-> o_prog_sel)
        else $error("upper address driven outside program space");

    a_host_low_input: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_host_port_wide_select)
        |-> (o_ext_address_bus_oe[LOW_W-1:0] == '0))
        else $error("low address driven in host mode");

    a_low_space_sel: assert property (@(posedge i_clk) disable iff (i_rst)
        (|o_ext_address_bus_oe[LOW_W-1:0])
        |-> $onehot({o_prog_sel, o_data_sel, o_io_sel}))
        else $error("low address without one space strobe");

    a_addr_keeper: assert property (@(posedge i_clk) disable iff (i_rst)
        (!$past(i_rst) && ctrl_reg[CTRL_AHOLD_BIT]
         && $past(ctrl_reg[CTRL_AHOLD_BIT]))
        |-> (o_ext_address_bus_keep_en == ~o_ext_address_bus_oe))
        else $error("address keeper not covering floating lines");

    a_data_keeper: assert property (@(posedge i_clk) disable iff (i_rst)
        (!$past(i_rst) && $past(ctrl_reg[CTRL_DHOLD_BIT])
         && !o_ext_data_bus_oe[0])
        |-> o_ext_data_bus_keep_en[0])
        else $error("data keeper idle on floating line");

    a_data_keep_off: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(ctrl_reg[CTRL_DHOLD_BIT])
        |-> (o_ext_data_bus_keep_en == '0))
        else $error("data keeper active while disabled");

    a_host_data_src: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_host_port_wide_select && i_off_n && i_device_reset_n
         && !i_hold_req && i_host_rd.drive)
        |=> (o_ext_data_bus == $past(i_host_rd.rdata))
            && (o_ext_data_bus_oe != '0))
        else $error("host read data not on data bus");

    a_apb_one_wait: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && !i_penable) ##1 (i_psel && i_penable)
        |-> !o_pready ##1 o_pready)
        else $error("APB answer not one cycle into access");

endmodule // ebp_pin_ctrl

`default_nettype wire

// *** pkg/ebp_pkg.sv ***
/*
 * Package for the external bus pin control block: bus widths, register
 * offsets and field positions, reset values, access kinds and the packed
 * carriers that group the core's request and the host-port read data.
 * Assumes a single 250 MHz clock and an APB register bus with 32-bit data.
 */
`default_nettype none

package ebp_pkg;

    // Pin widths
    localparam int ADDR_W = 23;
    localparam int LOW_W  = 16;
    localparam int HIGH_W = ADDR_W - LOW_W;
    localparam int DATA_W = 16;

    // Clock period in ns, kept for reference by timing counts
    localparam int CLK_PERIOD_NS = 4;

    // APB register map (byte addresses)
    localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

    // Control register fields
    localparam int CTRL_DHOLD_BIT = 0;
    localparam int CTRL_AHOLD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Status register fields
    localparam int STAT_HOLDACK_BIT = 0;
    localparam int STAT_HOST_BIT    = 1;
    localparam int STAT_OFF_BIT     = 2;
    localparam int STAT_ADRV_BIT    = 3;
    localparam int STAT_DDRV_BIT    = 4;
    localparam int STAT_RESET_BIT   = 5;

    // Kind of external access requested by the core
    typedef enum logic [1:0] {
        EBP_KIND_NONE,
        EBP_KIND_PROG,
        EBP_KIND_DATA,
        EBP_KIND_IO
    } ebp_kind_t;

    // Ownership of the external bus
    typedef enum logic {
        EBP_BUS_OWN,
        EBP_BUS_HELD
    } ebp_bus_state_t;

    // Core request toward the external bus
    typedef struct packed {
        logic                    req;
        ebp_kind_t               kind;
        logic                    wr;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       wdata;
    } ebp_core_req_t;

    // Host-port read data offered to the pins
    typedef struct packed {
        logic                    drive;
        logic [DATA_W-1:0]       rdata;
    } ebp_host_rd_t;

endpackage : ebp_pkg

`default_nettype wire

// *** tb/ebp_far_model.sv ***
/*
 * Far side of the external bus: a host that drives the low address lines
 * and the data lines in wide host mode, and the wires that resolve every
 * pin from strong drive, host drive and keeper.
 * Assumes all enables come from the pin control block on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ebp_far_model
    import ebp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic [ADDR_W-1:0] i_a_out,
    input  wire logic [ADDR_W-1:0] i_a_oe,
    input  wire logic [ADDR_W-1:0] i_a_keep,
    input  wire logic [ADDR_W-1:0] i_a_keep_en,
    input  wire logic [DATA_W-1:0] i_d_out,
    input  wire logic [DATA_W-1:0] i_d_oe,
    input  wire logic [DATA_W-1:0] i_d_keep,
    input  wire logic [DATA_W-1:0] i_d_keep_en,
    input  wire logic              i_host_mode,
    input  wire logic              i_host_wr,
    input  wire logic [LOW_W-1:0]  i_host_addr,
    input  wire logic [DATA_W-1:0] i_host_data,
    output var  logic [ADDR_W-1:0] o_addr,
    output var  logic [DATA_W-1:0] o_data
);
    logic [ADDR_W-1:0] a_last_reg = '0;
    logic [DATA_W-1:0] d_last_reg = '0;
    logic [ADDR_W-1:0] host_a;

    assign host_a = ADDR_W'(i_host_addr);

    // Undriven lines have no pull, so they show the inverse of their last
    // held level; a float that nobody keeps is then visible at once
    always_comb begin
        for (int b = 0; b < ADDR_W; b++) begin
            if (i_a_oe[b]) o_addr[b] = i_a_out[b];
            else if (i_host_mode && b < LOW_W) o_addr[b] = host_a[b];
            else if (i_a_keep_en[b]) o_addr[b] = i_a_keep[b];
            else o_addr[b] = ~a_last_reg[b];
        end
        for (int b = 0; b < DATA_W; b++) begin
            if (i_d_oe[b]) o_data[b] = i_d_out[b];
            else if (i_host_mode && i_host_wr) o_data[b] = i_host_data[b];
            else if (i_d_keep_en[b]) o_data[b] = i_d_keep[b];
            else o_data[b] = ~d_last_reg[b];
        end
    end

    // Remember the level each line last showed while something held it
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < ADDR_W; b++) begin
            if (i_a_oe[b] || i_a_keep_en[b] || (i_host_mode && b < LOW_W)) begin
                a_last_reg[b] <= o_addr[b];
            end
        end
        for (int b = 0; b < DATA_W; b++) begin
            if (i_d_oe[b] || i_d_keep_en[b] || (i_host_mode && i_host_wr)) begin
                d_last_reg[b] <= o_data[b];
            end
        end
    end
endmodule // ebp_far_model

`default_nettype wire

// *** tb/ebp_pin_ctrl_tb.sv ***
/*
 * Self-checking bench for the external bus pin control block: APB registers,
 * a table of pin cases, then keepers, host mode, output disable and status.
 * Assumes the one-cycle pin latency and one APB wait state of the design.
 */
`timescale 1ns/1ps
`default_nettype none

module ebp_pin_ctrl_tb
    import ebp_pkg::*;
;
    typedef struct packed {
        logic off_n, rst_n, hold, host;
        ebp_kind_t kind;
        logic wr, alo, ahi, doe;
        logic [2:0] sel;
        logic ack;
    } ebp_row_t;

    logic i_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic off_n = 1, dev_rst_n = 1, hold = 0, host = 0, host_wr = 0, err;
    logic hold_ack, prog_sel, data_sel, io_sel;
    logic [LOW_W-1:0] host_addr = 16'h0000, h_addr;
    logic [DATA_W-1:0] host_data = 16'h0000, h_wdata, core_rdata;
    logic [DATA_W-1:0] d_pin, d_out, d_oe, d_keep, d_keep_en;
    logic [ADDR_W-1:0] a_pin, a_out, a_oe, a_keep, a_keep_en;
    ebp_core_req_t core = '0;
    ebp_host_rd_t hrd = '0;
    int error_cnt = 0, samples_checked = 0;
    ebp_row_t rows [8] = '{
        '{1, 1, 0, 0, EBP_KIND_PROG, 1, 1, 1, 1, 3'h4, 0},
        '{1, 1, 0, 0, EBP_KIND_DATA, 0, 1, 0, 0, 3'h2, 0},
        '{1, 1, 0, 0, EBP_KIND_IO,   1, 1, 0, 1, 3'h1, 0},
        '{1, 1, 0, 0, EBP_KIND_NONE, 1, 0, 0, 0, 3'h0, 0},
        '{0, 1, 0, 0, EBP_KIND_PROG, 1, 0, 0, 0, 3'h0, 0},
        '{1, 1, 1, 0, EBP_KIND_PROG, 1, 0, 0, 0, 3'h0, 1},
        '{1, 0, 0, 0, EBP_KIND_PROG, 1, 1, 1, 0, 3'h4, 0},
        '{1, 1, 0, 1, EBP_KIND_NONE, 0, 0, 0, 0, 3'h0, 0}};

    ebp_pin_ctrl i_ebp_pin_ctrl (.i_clk(i_clk), .i_rst(i_rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(perr), .i_off_n(off_n), .i_device_reset_n(dev_rst_n),
        .i_hold_req(hold), .i_host_port_wide_select(host), .i_core(core),
        .i_host_rd(hrd), .o_hold_ack(hold_ack), .o_prog_sel(prog_sel),
        .o_data_sel(data_sel), .o_io_sel(io_sel),
        .o_core_rdata(core_rdata), .o_host_addr(h_addr),
        .o_host_wdata(h_wdata), .i_ext_address_bus(a_pin),
        .o_ext_address_bus(a_out), .o_ext_address_bus_oe(a_oe),
        .o_ext_address_bus_keep(a_keep),
        .o_ext_address_bus_keep_en(a_keep_en), .i_ext_data_bus(d_pin),
        .o_ext_data_bus(d_out), .o_ext_data_bus_oe(d_oe),
        .o_ext_data_bus_keep(d_keep), .o_ext_data_bus_keep_en(d_keep_en));

    ebp_far_model i_ebp_far_model (.i_clk(i_clk), .i_a_out(a_out),
        .i_a_oe(a_oe), .i_a_keep(a_keep), .i_a_keep_en(a_keep_en),
        .i_d_out(d_out), .i_d_oe(d_oe), .i_d_keep(d_keep),
        .i_d_keep_en(d_keep_en), .i_host_mode(host), .i_host_wr(host_wr),
        .i_host_addr(host_addr), .i_host_data(host_data),
        .o_addr(a_pin), .o_data(d_pin));

    // 250 MHz clock
    initial begin
        forever #2 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Let one input edge land, then look between edges
    task automatic settle;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask

    // APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge i_clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) error_cnt++;
        rd = prdata;
        err = perr;
        psel <= 0; pen <= 0;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 0;
        apb(0, CTRL_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        apb(1, STATUS_OFFSET, 32'h0000_001F);
        check(err, 1);
        apb(0, 32'h0000_0008, 32'h0000_0000);
        check(err, 1);
        check(rd, 32'h0000_0000);
        // Table of pin cases
        foreach (rows[i]) begin
            @(posedge i_clk);
            off_n <= rows[i].off_n; dev_rst_n <= rows[i].rst_n;
            hold <= rows[i].hold; host <= rows[i].host;
            core <= '{1'b1, rows[i].kind, rows[i].wr, 23'h55_1234, 16'hA5C3};
            settle();
            check(a_oe, {{HIGH_W{rows[i].ahi}}, {LOW_W{rows[i].alo}}});
            check(d_oe, {DATA_W{rows[i].doe}});
            check(hold_ack, rows[i].ack);
            if (rows[i].alo) check({prog_sel, data_sel, io_sel}, rows[i].sel);
        end
        // Core write, then float onto the keepers
        @(posedge i_clk);
        off_n <= 1; dev_rst_n <= 1; hold <= 0; host <= 0;
        core <= '{1'b1, EBP_KIND_DATA, 1'b1, 23'h55_1234, 16'hA5C3};
        settle();
        check(d_pin, 16'hA5C3);
        @(posedge i_clk);
        core.req <= 0;
        settle();
        settle();
        check(d_pin, 16'hA5C3);
        check(a_pin[LOW_W-1:0], 16'h1234);
        check(core_rdata, 16'hA5C3);
        apb(1, CTRL_OFFSET, 32'h0000_0000);
        settle();
        check(d_keep_en, 16'h0000);
        check(d_pin == 16'hA5C3, 0);
        // Host mode: host drives the low address and the data lines
        @(posedge i_clk);
        host <= 1; host_addr <= 16'hBEEF; host_wr <= 1; host_data <= 16'h1357;
        settle();
        settle();
        check(a_oe[LOW_W-1:0], 16'h0000);
        check(h_addr, 16'hBEEF);
        check(h_wdata, 16'h1357);
        @(posedge i_clk);
        host_wr <= 0;
        hrd <= '{1'b1, 16'h2468};
        settle();
        check(d_oe, 16'hFFFF);
        check(d_pin, 16'h2468);
        @(posedge i_clk);
        off_n <= 0;
        core <= '{1'b1, EBP_KIND_PROG, 1'b1, 23'h7F_FFFF, 16'hFFFF};
        settle();
        check(a_oe, 23'h0);
        check(d_oe, 16'h0);
        check(a_keep_en[ADDR_W-1:LOW_W], 7'h00);
        // Status shows the hold acknowledge
        @(posedge i_clk);
        off_n <= 1; host <= 0; hrd <= '0; hold <= 1;
        settle();
        check(a_oe, 23'h0);
        apb(0, STATUS_OFFSET, 32'h0000_0000);
        check(rd[STAT_HOLDACK_BIT], 1);
        report_and_stop();
    end
endmodule // ebp_pin_ctrl_tb

`default_nettype wire
